/* File: framer_control.v */
// Purpose: Control register, overhead insertion, loopbacks and counter gating
// Assumes: Formatter slot strobes and error events arrive on clk_i
// Notes:   Line receive pins are synchronised; their clock is sampled, not used
`timescale 1ns/1ps
`include "framer_defines.vh"

module framer_control (
  input  wire                 clk_i,
  input  wire                 reset_i,
  // Register port
  input  wire [`ADDR_W-1:0]   reg_addr_i,
  input  wire [`DATA_W-1:0]   reg_wdata_i,
  input  wire                 reg_write_i,
  input  wire                 reg_read_i,
  output reg  [`DATA_W-1:0]   reg_rdata_o,
  // Mode straps from device configuration
  input  wire                 e3_mode_i,
  input  wire                 cbit_parity_mode_i,
  input  wire                 framer_resync_i,
  output reg                  framer_resync_o,
  // Formatter slot stream
  input  wire                 slot_valid_i,
  input  wire [`SLOT_W-1:0]   slot_kind_i,
  input  wire [2:0]           slot_subframe_i,
  input  wire                 slot_data_i,
  input  wire                 rx_framed_data_i,
  input  wire                 hdlc_tx_sn_i,
  input  wire                 feac_tx_sn_i,
  input  wire                 block_error_seen_i,
  output reg                  tx_bit_o,
  output reg                  tx_bit_valid_o,
  // Received national bit
  input  wire                 rx_sn_valid_i,
  input  wire                 rx_sn_i,
  output reg                  hdlc_rx_sn_o,
  output reg                  feac_rx_sn_o,
  output reg                  rx_sn_valid_o,
  // Encoded formatter output and line pins
  input  wire                 fmt_tx_clock_i,
  input  wire                 fmt_tx_positive_i,
  input  wire                 fmt_tx_negative_i,
  input  wire                 line_rx_clock_i,
  input  wire                 line_rx_positive_i,
  input  wire                 line_rx_negative_i,
  output reg                  line_tx_clock_o,
  output reg                  line_tx_positive_o,
  output reg                  line_tx_negative_o,
  output reg                  framer_rx_clock_o,
  output reg                  framer_rx_positive_o,
  output reg                  framer_rx_negative_o,
  // Error events from the receive framer and decoder
  input  wire                 lof_i,
  input  wire                 lof_start_i,
  input  wire                 f_error_i,
  input  wire                 m_error_i,
  input  wire                 fas_bit_error_i,
  input  wire                 fas_word_error_i,
  input  wire                 bpv_i,
  input  wire                 cv_i,
  input  wire                 parity_error_i,
  input  wire                 cparity_error_i,
  input  wire                 block_error_i,
  output reg                  violation_inc_o,
  output reg                  frame_error_inc_o,
  output reg                  parity_inc_o,
  output reg                  cparity_inc_o,
  output reg                  block_error_inc_o
);

  // --------------------
  // Control register fields
  // --------------------
  reg  [`DATA_W-1:0] framer_control_q;
  reg                rx_sn_q;
  reg                alt_q;
  reg  [1:0]         idle_q;
  reg  [1:0]         sn_pick;
  reg                tx_bit_d;
  reg                frame_hit;
  wire [2:0]         line_sync_w;

  wire send_alarm     = framer_control_q[`B_SEND_ALARM_IND];
  wire send_remote    = framer_control_q[`B_SEND_REMOTE_ALARM];
  wire pass_through   = framer_control_q[`B_PASS_THROUGH];
  wire send_idle      = framer_control_q[`B_SEND_IDLE];
  wire line_loop      = framer_control_q[`B_LINE_LOOPBACK];
  wire diag_loop      = framer_control_q[`B_DIAG_LOOPBACK];
  wire cv_select      = framer_control_q[`B_CV_SELECT];
  wire count_in_lof   = framer_control_q[`B_COUNT_IN_LOF];
  wire auto_defeat    = framer_control_q[`B_AUTO_BE_DEFEAT];
  wire forced_value   = framer_control_q[`B_FORCED_BE_VALUE];
  wire payload_loop   = framer_control_q[`B_PAYLOAD_LOOPBACK];
  wire [1:0] sn_src   = {framer_control_q[`B_SN_SOURCE_HI],
                         framer_control_q[`B_SN_SOURCE_LO]};
  wire [1:0] fsel     = {framer_control_q[`B_FRAME_SEL_HI],
                         framer_control_q[`B_FRAME_SEL_LO]};

  // Address match shared by the write and read paths
  function is_addr;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  // --------------------
  // Register write and read; unmapped reads return zero
  // --------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      framer_control_q <= `RST_FRAMER_CONTROL;
    end else if (reg_write_i && is_addr(reg_addr_i, `OFS_FRAMER_CONTROL)) begin
      framer_control_q <= reg_wdata_i & `CTRL_WR_MASK; // Bit 15 reads zero
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= {`DATA_W{1'b0}};
    end else if (reg_read_i && is_addr(reg_addr_i, `OFS_FRAMER_CONTROL)) begin
      reg_rdata_o <= framer_control_q;
    end else if (reg_read_i && is_addr(reg_addr_i, `OFS_FRAMER_INFO)) begin
      reg_rdata_o <= {{(`DATA_W-3){1'b0}}, cbit_parity_mode_i, e3_mode_i, rx_sn_q};
    end else begin
      reg_rdata_o <= {`DATA_W{1'b0}};
    end
  end

  // --------------------
  // Resync request and received national bit
  // --------------------
  // Resync lives in the master register; forwarded here and also restarts the fill
  always @(posedge clk_i) begin
    if (reset_i) begin
      framer_resync_o <= 1'b0;
    end else begin
      framer_resync_o <= framer_resync_i;
    end
  end

  // Sn is delivered regardless of the transmit source field
  always @(posedge clk_i) begin
    if (reset_i) begin
      rx_sn_q       <= 1'b0;
      hdlc_rx_sn_o  <= 1'b0;
      feac_rx_sn_o  <= 1'b0;
      rx_sn_valid_o <= 1'b0;
    end else begin
      rx_sn_valid_o <= rx_sn_valid_i & e3_mode_i;
      if (rx_sn_valid_i && e3_mode_i) begin
        rx_sn_q      <= rx_sn_i;
        hdlc_rx_sn_o <= rx_sn_i;
        feac_rx_sn_o <= rx_sn_i;
      end
    end
  end

  // --------------------
  // Fill pattern generators, stepped on information bits only
  // --------------------
  // Resync restarts the fill so alarms start on a clean phase
  always @(posedge clk_i) begin
    if (reset_i || framer_resync_i) begin
      alt_q  <= 1'b1;
      idle_q <= 2'd0;
    end else if (slot_valid_i && slot_kind_i == `SLOT_INFO) begin
      alt_q  <= ~alt_q;
      idle_q <= idle_q + 2'd1;
    end
  end

  // National bit source select
  always @* begin
    case (sn_src)
      `SN_FORCE_ONE:  sn_pick = 2'b01;
      `SN_FROM_HDLC:  sn_pick = {1'b0, hdlc_tx_sn_i};
      `SN_FROM_FEAC:  sn_pick = {1'b0, feac_tx_sn_i};
      default:        sn_pick = 2'b00;
    endcase
  end

  // --------------------
  // Overhead and payload bit selection
  // --------------------
  // In T3, alarm beats idle, and both keep framing even when pass-through is set; the E3 alarm sends all ones;
  // pass-through only affects normal traffic.
  always @* begin
    tx_bit_d = payload_loop ? rx_framed_data_i : slot_data_i;
    if (e3_mode_i) begin
      if (send_alarm) begin
        tx_bit_d = 1'b1;
      end else if (!pass_through) begin
        case (slot_kind_i)
          `SLOT_E3_RAI: tx_bit_d = send_remote;
          `SLOT_E3_SN:  tx_bit_d = sn_pick[0];
          default:      tx_bit_d = tx_bit_d;
        endcase
      end
    end else if (send_alarm) begin
      case (slot_kind_i)
        `SLOT_INFO: tx_bit_d = alt_q;
        `SLOT_X:    tx_bit_d = 1'b1;
        `SLOT_C:    tx_bit_d = 1'b0;
        default:    tx_bit_d = slot_data_i;
      endcase
    end else if (send_idle) begin
      case (slot_kind_i)
        `SLOT_INFO: tx_bit_d = ~idle_q[1];
        `SLOT_X:    tx_bit_d = 1'b1;
        `SLOT_C:    tx_bit_d = (slot_subframe_i == `SUBFRAME_IDLE_C) ? 1'b0 : slot_data_i;
        default:    tx_bit_d = slot_data_i;
      endcase
    end else if (!pass_through) begin
      case (slot_kind_i)
        `SLOT_X: tx_bit_d = ~send_remote;
        `SLOT_C: begin
          if (cbit_parity_mode_i && slot_subframe_i == `SUBFRAME_BE_C) begin
            if (auto_defeat) begin
              tx_bit_d = ~forced_value;
            end else begin
              tx_bit_d = ~block_error_seen_i;
            end
          end
        end
        default: tx_bit_d = tx_bit_d;
      endcase
    end
  end

  // Registered slot output
  always @(posedge clk_i) begin
    if (reset_i) begin
      tx_bit_o       <= 1'b0;
      tx_bit_valid_o <= 1'b0;
    end else begin
      tx_bit_valid_o <= slot_valid_i;
      if (slot_valid_i) begin
        tx_bit_o <= tx_bit_d;
      end
    end
  end

  // --------------------
  // Loopback steering of the bipolar pins
  // --------------------
  line_sync #(
    .W (3)
  ) u_line_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({line_rx_clock_i, line_rx_positive_i, line_rx_negative_i}),
    .sync_o  (line_sync_w)
  );

  // Line loopback costs three cycles of skew versus the raw pins; the
  // sampled clock is rebuilt at clk_i resolution only.
  always @(posedge clk_i) begin
    if (reset_i) begin
      line_tx_clock_o      <= 1'b0;
      line_tx_positive_o   <= 1'b0;
      line_tx_negative_o   <= 1'b0;
      framer_rx_clock_o    <= 1'b0;
      framer_rx_positive_o <= 1'b0;
      framer_rx_negative_o <= 1'b0;
    end else begin
      if (line_loop) begin
        line_tx_clock_o    <= line_sync_w[2];
        line_tx_positive_o <= line_sync_w[1];
        line_tx_negative_o <= line_sync_w[0];
      end else begin
        line_tx_clock_o    <= fmt_tx_clock_i;
        line_tx_positive_o <= fmt_tx_positive_i;
        line_tx_negative_o <= fmt_tx_negative_i;
      end
      if (diag_loop) begin
        framer_rx_clock_o    <= fmt_tx_clock_i;
        framer_rx_positive_o <= fmt_tx_positive_i;
        framer_rx_negative_o <= fmt_tx_negative_i;
      end else begin
        framer_rx_clock_o    <= line_sync_w[2];
        framer_rx_positive_o <= line_sync_w[1];
        framer_rx_negative_o <= line_sync_w[0];
      end
    end
  end

  // --------------------
  // Counter source selection and loss-of-frame gating
  // --------------------
  // The illegal E3 select counts nothing
  always @* begin
    case (fsel)
      `FSEL_LOF:     frame_hit = lof_start_i;
      `FSEL_F_AND_M: frame_hit = e3_mode_i ? fas_bit_error_i : (f_error_i | m_error_i);
      `FSEL_F_ONLY:  frame_hit = e3_mode_i ? fas_word_error_i : f_error_i;
      default:       frame_hit = e3_mode_i ? 1'b0 : m_error_i;
    endcase
  end

  wire count_ok = count_in_lof | ~lof_i;

  always @(posedge clk_i) begin
    if (reset_i) begin
      violation_inc_o   <= 1'b0;
      frame_error_inc_o <= 1'b0;
      parity_inc_o      <= 1'b0;
      cparity_inc_o     <= 1'b0;
      block_error_inc_o <= 1'b0;
    end else begin
      violation_inc_o   <= (e3_mode_i && cv_select) ? cv_i : bpv_i;
      frame_error_inc_o <= frame_hit & ((fsel == `FSEL_LOF) | count_ok);
      parity_inc_o      <= parity_error_i & ~e3_mode_i & count_ok;
      cparity_inc_o     <= cparity_error_i & ~e3_mode_i & count_ok;
      block_error_inc_o <= block_error_i & count_ok;
    end
  end

endmodule

/* File: framer_defines.vh */
// Purpose: Shared constants of the T3/E3 framer control block
// Assumes: Included by its bare name from every design file
// Notes:   Offsets are byte addresses on the plain register port
`ifndef FRAMER_DEFINES_VH
`define FRAMER_DEFINES_VH

// --------------------
// Register map
// --------------------
`define ADDR_W                 8
`define DATA_W                 16
`define OFS_FRAMER_CONTROL     8'h10
`define OFS_FRAMER_INFO        8'h14
`define RST_FRAMER_CONTROL     16'h0000
`define CTRL_WR_MASK           16'h7fff

// --------------------
// Field positions of framer_control
// --------------------
`define B_SEND_ALARM_IND       0
`define B_SEND_REMOTE_ALARM    1
`define B_PASS_THROUGH         2
`define B_SN_SOURCE_LO         3
`define B_SN_SOURCE_HI         4
`define B_SEND_IDLE            5
`define B_LINE_LOOPBACK        6
`define B_DIAG_LOOPBACK        7
`define B_CV_SELECT            8
`define B_FRAME_SEL_LO         9
`define B_FRAME_SEL_HI         10
`define B_COUNT_IN_LOF         11
`define B_AUTO_BE_DEFEAT       12
`define B_FORCED_BE_VALUE      13
`define B_PAYLOAD_LOOPBACK     14

// --------------------
// Field positions of framer_info_register
// --------------------
`define B_INFO_RX_SN           0
`define B_INFO_E3_MODE         1
`define B_INFO_CBIT_MODE       2

// --------------------
// Encodings
// --------------------
`define SN_FORCE_ONE           2'b00
`define SN_FROM_HDLC           2'b01
`define SN_FROM_FEAC           2'b10
`define SN_FORCE_ZERO          2'b11
`define FSEL_LOF               2'b00
`define FSEL_F_AND_M           2'b01
`define FSEL_F_ONLY            2'b10
`define FSEL_M_ONLY            2'b11
`define SLOT_W                 4
`define SLOT_INFO              4'h0
`define SLOT_F                 4'h1
`define SLOT_M                 4'h2
`define SLOT_P                 4'h3
`define SLOT_X                 4'h4
`define SLOT_C                 4'h5
`define SLOT_E3_FAS            4'h6
`define SLOT_E3_RAI            4'h7
`define SLOT_E3_SN             4'h8
`define SLOT_E3_PAYLOAD        4'h9
`define SUBFRAME_IDLE_C        3'd3
`define SUBFRAME_BE_C          3'd4
`define SYNC_STAGES            2

`endif

/* File: line_sync.v */
// Purpose: Two-stage synchroniser for the receive line pins
// Assumes: Inputs are asynchronous to clk_i
// Notes:   First stage feeds the second stage only
`timescale 1ns/1ps
`include "framer_defines.vh"

module line_sync #(
  parameter W = 3
) (
  input  wire         clk_i,
  input  wire         reset_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // --------------------
  // Per-bit flop pair; stage one is never read by logic
  // --------------------
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (reset_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;

endmodule

/* File: framer_control_checker.sv */
// Purpose: Port-level assertions for the framer control block
// Assumes: Control word is shadowed from register port writes
// Notes:   Outputs are judged one cycle after their cause, line loopback three cycles after
`timescale 1ns/1ps

module framer_control_checker (
  input wire        clk_i, reset_i, reg_write_i, e3_mode_i, cbit_parity_mode_i,
  input wire [7:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire [3:0]  slot_kind_i,
  input wire [2:0]  slot_subframe_i,
  input wire        slot_valid_i, tx_bit_o, hdlc_tx_sn_i, feac_tx_sn_i, block_error_seen_i,
  input wire        line_rx_positive_i, line_tx_positive_o, fmt_tx_positive_i,
  input wire        framer_rx_positive_o, lof_i, lof_start_i, f_error_i, m_error_i,
  input wire        fas_bit_error_i, fas_word_error_i, bpv_i, cv_i, parity_error_i,
  input wire        block_error_i, violation_inc_o, frame_error_inc_o, parity_inc_o,
  input wire        block_error_inc_o
);
  // --------------------
  // Shadow control word and expected sources
  // --------------------
  reg  [15:0] ctrl_q;
  reg         frame_src;
  wire        t3_plain = slot_valid_i && !e3_mode_i && (ctrl_q & 16'h0025) == 16'h0000;
  wire        e3_plain = slot_valid_i && e3_mode_i && (ctrl_q & 16'h0005) == 16'h0000;
  wire        sn_exp   = ctrl_q[4] ? (!ctrl_q[3] && feac_tx_sn_i) : (!ctrl_q[3] || hdlc_tx_sn_i);
  wire        be_exp   = ctrl_q[12] ? !ctrl_q[13] : !block_error_seen_i;
  wire        gate     = ctrl_q[11] || !lof_i;

  // Bit 15 never stores, so the shadow drops it too
  always @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q <= 16'h0000;
    end else if (reg_write_i && reg_addr_i == 8'h10) begin
      ctrl_q <= reg_wdata_i & 16'h7fff;
    end
  end

  // Frame counter source; E3 has no M-only count
  always @* begin
    case (ctrl_q[10:9])
      2'b00:   frame_src = lof_start_i;
      2'b01:   frame_src = e3_mode_i ? fas_bit_error_i : (f_error_i || m_error_i);
      2'b10:   frame_src = e3_mode_i ? fas_word_error_i : f_error_i;
      default: frame_src = !e3_mode_i && m_error_i;
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // --------------------
  // Assertions
  // --------------------
  AST_T3_ALARM: assert property (slot_valid_i && !e3_mode_i && ctrl_q[0] &&
    (slot_kind_i == 4'h4 || slot_kind_i == 4'h5) |=> tx_bit_o == ($past(slot_kind_i) == 4'h4))
    else $error("alarm overhead bit wrong");
  AST_E3_ALARM: assert property (slot_valid_i && e3_mode_i && ctrl_q[0] |=> tx_bit_o)
    else $error("E3 alarm bit not one");
  AST_T3_REMOTE: assert property (t3_plain && slot_kind_i == 4'h4
    |=> tx_bit_o == !$past(ctrl_q[1])) else $error("X bit wrong");
  AST_E3_RAI: assert property (e3_plain && slot_kind_i == 4'h7
    |=> tx_bit_o == $past(ctrl_q[1])) else $error("E3 alarm bit wrong");
  AST_SN_SOURCE: assert property (e3_plain && slot_kind_i == 4'h8
    |=> tx_bit_o == $past(sn_exp)) else $error("national bit wrong");
  AST_BLOCK_CODE: assert property (t3_plain && cbit_parity_mode_i && slot_kind_i == 4'h5
    && slot_subframe_i == 3'd4 |=> tx_bit_o == $past(be_exp)) else $error("block code wrong");
  AST_LINE_LOOP: assert property (!$past(reset_i, 4) && $past(ctrl_q[6])
    |-> line_tx_positive_o == $past(line_rx_positive_i, 3)) else $error("line loop wrong");
  AST_DIAG_LOOP: assert property (!$past(reset_i) && $past(ctrl_q[7])
    |-> framer_rx_positive_o == $past(fmt_tx_positive_i)) else $error("diag loop wrong");
  AST_VIOLATION: assert property (!$past(reset_i) |-> violation_inc_o ==
    $past(e3_mode_i && ctrl_q[8] ? cv_i : bpv_i)) else $error("violation count wrong");
  AST_FRAME_COUNT: assert property (!$past(reset_i) |-> frame_error_inc_o ==
    $past(frame_src && (ctrl_q[10:9] == 2'b00 || gate))) else $error("frame count wrong");
  AST_LOF_GATE: assert property (!$past(reset_i) |->
    parity_inc_o == $past(parity_error_i && !e3_mode_i && gate) &&
    block_error_inc_o == $past(block_error_i && gate)) else $error("gated count wrong");

  COV_SN: cover property (e3_plain && slot_kind_i == 4'h8);
  COV_LOOP: cover property (ctrl_q[6] && line_tx_positive_o);
  COV_LOF: cover property (lof_i && ctrl_q[11] && parity_inc_o);
endmodule

bind framer_control framer_control_checker framer_control_checker_inst (.*);

/* File: line_unit_model.sv */
// Purpose: Behavioural line interface feeding the receive pins
// Assumes: Line clock runs free while enabled, 48 ns period
// Notes:   Marks alternate polarity so both rails never rise together
`timescale 1ns/1ps

module line_unit_model (
  input  wire run_i,
  output reg  line_rx_clock_o,
  output reg  line_rx_positive_o,
  output reg  line_rx_negative_o
);
  reg [2:0] pat_q;
  reg       pol_q;
  reg       mark;

  // Odd start offset keeps line edges away from the system clock edges
  initial begin
    line_rx_clock_o = 1'b0;
    line_rx_positive_o = 1'b0;
    line_rx_negative_o = 1'b0;
    pat_q = 3'd0;
    pol_q = 1'b0;
    #3.3;
    forever begin
      #24;
      if (!run_i) begin
        line_rx_clock_o = 1'b0;
        line_rx_positive_o = 1'b0;
        line_rx_negative_o = 1'b0;
      end else begin
        line_rx_clock_o = ~line_rx_clock_o;
        if (!line_rx_clock_o) begin
          pat_q = pat_q + 3'd1;
          mark = pat_q[0] ^ pat_q[2];
          pol_q = pol_q ^ mark;
          line_rx_positive_o = mark & pol_q;
          line_rx_negative_o = mark & ~pol_q;
        end
      end
    end
  end
endmodule

/* File: framer_control_bench.sv */
// Purpose: Self-checking bench for the framer control block
// Assumes: Control writes take effect one cycle after the strobe
// Notes:   Each scenario task judges its own results
`timescale 1ns/1ps

module framer_control_bench;
  reg         clk_i, reset_i, wr_q, rd_q, e3_q, cbit_q, rsy_q, sv_q, sd_q, pl_q;
  reg         hdlc_q, feac_q, bes_q, rsv_q, rsn_q, fclk_q, fpos_q, lof_q, run_q, prev_q;
  reg  [7:0]  addr_q;
  reg  [15:0] wdata_q;
  reg  [3:0]  kind_q;
  reg  [2:0]  sub_q;
  reg  [9:0]  ev_q;
  wire [15:0] rdata_w;
  wire [4:0]  inc_w;
  wire        bit_w, bval_w, hrx_w, frx_w, snv_w, lclk_w, lpos_w, lneg_w, tclk_w, rpos_w;
  integer     n_fail, samples_checked, i, n;

  framer_control framer_control_inst (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr_q),
    .reg_wdata_i(wdata_q), .reg_write_i(wr_q), .reg_read_i(rd_q), .reg_rdata_o(rdata_w),
    .e3_mode_i(e3_q), .cbit_parity_mode_i(cbit_q), .framer_resync_i(rsy_q),
    .framer_resync_o(), .slot_valid_i(sv_q), .slot_kind_i(kind_q), .slot_subframe_i(sub_q),
    .slot_data_i(sd_q), .rx_framed_data_i(pl_q), .hdlc_tx_sn_i(hdlc_q), .feac_tx_sn_i(feac_q),
    .block_error_seen_i(bes_q), .tx_bit_o(bit_w), .tx_bit_valid_o(bval_w),
    .rx_sn_valid_i(rsv_q), .rx_sn_i(rsn_q), .hdlc_rx_sn_o(hrx_w), .feac_rx_sn_o(frx_w),
    .rx_sn_valid_o(snv_w), .fmt_tx_clock_i(fclk_q), .fmt_tx_positive_i(fpos_q),
    .fmt_tx_negative_i(!fpos_q), .line_rx_clock_i(lclk_w), .line_rx_positive_i(lpos_w),
    .line_rx_negative_i(lneg_w), .line_tx_clock_o(tclk_w), .line_tx_positive_o(),
    .line_tx_negative_o(), .framer_rx_clock_o(), .framer_rx_positive_o(rpos_w),
    .framer_rx_negative_o(), .lof_i(lof_q), .lof_start_i(ev_q[9]), .f_error_i(ev_q[8]),
    .m_error_i(ev_q[7]), .fas_bit_error_i(ev_q[6]), .fas_word_error_i(ev_q[5]),
    .bpv_i(ev_q[4]), .cv_i(ev_q[3]), .parity_error_i(ev_q[2]), .cparity_error_i(ev_q[1]),
    .block_error_i(ev_q[0]), .violation_inc_o(inc_w[4]), .frame_error_inc_o(inc_w[3]),
    .parity_inc_o(inc_w[2]), .cparity_inc_o(inc_w[1]), .block_error_inc_o(inc_w[0]));

  line_unit_model line_unit_model_inst (.run_i(run_q), .line_rx_clock_o(lclk_w),
    .line_rx_positive_o(lpos_w), .line_rx_negative_o(lneg_w));

  // 200 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // --------------------
  // Bus, slot and event tasks
  // --------------------
  task check(input [8*12-1:0] what, input [15:0] exp, input [15:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      wr_q <= 1'b1; addr_q <= a; wdata_q <= d;
      @(posedge clk_i);
      wr_q <= 1'b0;
    end
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [15:0] exp);
    begin
      @(posedge clk_i);
      rd_q <= 1'b1; addr_q <= a;
      @(posedge clk_i);
      rd_q <= 1'b0;
      #1 check("rdata", exp, rdata_w);
      @(posedge clk_i);
      #1 check("rdata_idle", 16'h0000, rdata_w);
    end
  endtask

  task slot(input [3:0] k, input [2:0] s, input d, input e);
    begin
      @(posedge clk_i);
      sv_q <= 1'b1; kind_q <= k; sub_q <= s; sd_q <= d;
      @(posedge clk_i);
      sv_q <= 1'b0;
      #1 check("tx_bit", {14'h0000, 1'b1, e}, {14'h0000, bval_w, bit_w});
    end
  endtask

  task cnt(input [9:0] e, input [4:0] exp);
    begin
      @(posedge clk_i);
      ev_q <= e;
      @(posedge clk_i);
      ev_q <= 10'h000;
      #1 check("counters", {11'h000, exp}, {11'h000, inc_w});
    end
  endtask

  // Resync also restarts the fill patterns
  task resync;
    begin
      @(posedge clk_i);
      rsy_q <= 1'b1;
      @(posedge clk_i);
      rsy_q <= 1'b0;
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task t_regs;
    begin
      rd(8'h10, 16'h0000);
      wr(8'h10, 16'hffff);
      rd(8'h10, 16'h7fff);
      wr(8'h20, 16'h1234);
      rd(8'h20, 16'h0000);
      wr(8'h10, 16'h0000);
      $display("t_regs done");
    end
  endtask

  task t_t3_tx;
    begin
      cbit_q <= 1'b1; wr(8'h10, 16'h0021); resync;
      slot(4'h0, 3'd1, 0, 1); slot(4'h0, 3'd1, 1, 0);
      slot(4'h0, 3'd1, 0, 1); slot(4'h0, 3'd1, 1, 0);
      slot(4'h4, 3'd1, 0, 1); slot(4'h5, 3'd4, 1, 0); slot(4'h1, 3'd1, 0, 0);
      wr(8'h10, 16'h0022); resync;
      slot(4'h0, 3'd1, 0, 1); slot(4'h0, 3'd1, 0, 1);
      slot(4'h0, 3'd1, 1, 0); slot(4'h0, 3'd1, 1, 0);
      slot(4'h4, 3'd2, 0, 1); slot(4'h5, 3'd3, 1, 0);
      wr(8'h10, 16'h0002); slot(4'h4, 3'd2, 1, 0);
      wr(8'h10, 16'h0000); slot(4'h4, 3'd2, 0, 1);
      bes_q <= 1'b1; slot(4'h5, 3'd4, 1, 0);
      bes_q <= 1'b0; slot(4'h5, 3'd4, 0, 1);
      wr(8'h10, 16'h1000); bes_q <= 1'b1; slot(4'h5, 3'd4, 0, 1);
      wr(8'h10, 16'h3000); bes_q <= 1'b0; slot(4'h5, 3'd4, 1, 0);
      wr(8'h10, 16'h0006); slot(4'h4, 3'd2, 1, 1); slot(4'h1, 3'd1, 0, 0);
      wr(8'h10, 16'h4004); pl_q <= 1'b1; slot(4'h0, 3'd1, 0, 1);
      pl_q <= 1'b0; slot(4'h0, 3'd1, 1, 0);
      $display("t_t3_tx done");
    end
  endtask

  task t_e3_tx;
    begin
      e3_q <= 1'b1; cbit_q <= 1'b0;
      wr(8'h10, 16'h0001); slot(4'h9, 3'd1, 0, 1); slot(4'h6, 3'd1, 0, 1);
      wr(8'h10, 16'h0002); slot(4'h7, 3'd1, 0, 1); slot(4'h9, 3'd1, 0, 0);
      wr(8'h10, 16'h0000); slot(4'h7, 3'd1, 1, 0);
      for (i = 0; i < 8; i = i + 1) begin
        hdlc_q <= i[2]; feac_q <= !i[2]; wr(8'h10, {11'h000, i[1:0], 3'b000});
        slot(4'h8, 3'd1, 0, 8'b0011_0101 >> i);
      end
      @(posedge clk_i);
      rsv_q <= 1'b1; rsn_q <= 1'b1;
      @(posedge clk_i);
      rsv_q <= 1'b0;
      #1 check("rx_sn", 16'h0007, {13'h0000, snv_w, hrx_w, frx_w});
      rd(8'h14, 16'h0003);
      e3_q <= 1'b0;
      $display("t_e3_tx done");
    end
  endtask

  task t_loops;
    begin
      run_q <= 1'b1; wr(8'h10, 16'h0040); n = 0; prev_q = tclk_w;
      repeat (200) begin
        @(posedge clk_i);
        if (tclk_w !== prev_q) n = n + 1;
        prev_q = tclk_w;
      end
      check("tx_clk_edges", 16'h0001, {15'h0000, n >= 10});
      wr(8'h10, 16'h0080); fclk_q <= 1'b1; fpos_q <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1 check("loop_pins", 16'h0003, {14'h0000, rpos_w, tclk_w});
      fpos_q <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1 check("loop_pins", 16'h0001, {14'h0000, rpos_w, tclk_w});
      run_q <= 1'b0; wr(8'h10, 16'h0000);
      $display("t_loops done");
    end
  endtask

  task t_counts;
    begin
      cbit_q <= 1'b1;
      wr(8'h10, 16'h0200); cnt(10'h100, 5'b01000); cnt(10'h080, 5'b01000);
      wr(8'h10, 16'h0400); cnt(10'h080, 5'b00000); cnt(10'h100, 5'b01000);
      wr(8'h10, 16'h0600); cnt(10'h080, 5'b01000); cnt(10'h100, 5'b00000);
      lof_q <= 1'b1; wr(8'h10, 16'h0200); cnt(10'h107, 5'b00000);
      wr(8'h10, 16'h0000); cnt(10'h200, 5'b01000);
      wr(8'h10, 16'h0a00); cnt(10'h107, 5'b01111);
      lof_q <= 1'b0; wr(8'h10, 16'h0100); cnt(10'h010, 5'b10000);
      e3_q <= 1'b1; cnt(10'h010, 5'b00000); cnt(10'h008, 5'b10000);
      wr(8'h10, 16'h0000); cnt(10'h010, 5'b10000); cnt(10'h008, 5'b00000);
      wr(8'h10, 16'h0200); cnt(10'h040, 5'b01000);
      wr(8'h10, 16'h0400); cnt(10'h020, 5'b01000); cnt(10'h040, 5'b00000);
      wr(8'h10, 16'h0600); cnt(10'h1e0, 5'b00000);
      e3_q <= 1'b0;
      $display("t_counts done");
    end
  endtask

  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // Main sequence: every input given a value at time zero
  initial begin
    n_fail = 0; samples_checked = 0; reset_i = 1'b1; wr_q = 0; rd_q = 0; e3_q = 0;
    cbit_q = 0; rsy_q = 0; sv_q = 0; sd_q = 0; pl_q = 0; hdlc_q = 0; feac_q = 0; bes_q = 0;
    rsv_q = 0; rsn_q = 0; fclk_q = 0; fpos_q = 0; lof_q = 0; run_q = 0; addr_q = 8'h00;
    wdata_q = 16'h0000; kind_q = 4'h0; sub_q = 3'd1; ev_q = 10'h000;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs; t_t3_tx; t_e3_tx; t_loops; t_counts;
    final_report;
  end

  // Whole run needs well under 10 us
  initial begin
    #50000;
    n_fail = n_fail + 1;
    $display("[FAIL] watchdog expected done seen hang");
    final_report;
  end
endmodule
